/* src/spi_port.sv */
`timescale 1ns/1ps
`include "spi_port_params.svh"
module spi_port
(
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// wishbone slave
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [9:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	// interrupt
	output logic             irq_o,
	input  wire logic        irq_ack_i,
	// serial clock pin
	input  wire logic        sclk_i,
	output logic             sclk_o,
	output logic             sclk_oe_o,
	// data pins (master_out_line, master_in_line)
	input  wire logic        mosi_i,
	output logic             mosi_o,
	output logic             mosi_oe_o,
	input  wire logic        miso_i,
	output logic             miso_o,
	output logic             miso_oe_o,
	// select pin
	input  wire logic        ss_n_i,
	output logic             ss_n_o,
	output logic             ss_n_oe_o
);
	// ***************************************
	// pin synchronisers
	// ***************************************
	logic [1:0] sclk_s_ff;
	logic [1:0] mosi_s_ff;
	logic [1:0] miso_s_ff;
	logic [1:0] ss_s_ff;
	logic       sclk_q_ff;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sclk_s_ff <= 2'b00;
			mosi_s_ff <= 2'b00;
			miso_s_ff <= 2'b00;
			ss_s_ff   <= 2'b11;
			sclk_q_ff <= 1'b0;
		end
		else
		begin
			sclk_s_ff <= {sclk_s_ff[0], sclk_i};
			mosi_s_ff <= {mosi_s_ff[0], mosi_i};
			miso_s_ff <= {miso_s_ff[0], miso_i};
			ss_s_ff   <= {ss_s_ff[0], ss_n_i};
			sclk_q_ff <= sclk_s_ff[1];
		end
	end

	// ***************************************
	// registers
	// ***************************************
	spi_port_pkg::byte_t control_ff;
	spi_port_pkg::byte_t tx_ff;
	spi_port_pkg::byte_t rx_ff;
	logic [7:0] mask_ff;
	logic [1:0] pin_ctrl_ff;
	logic       done_ff;
	logic       write_collision_flag_ff;
	logic       ss_high_ff;
	logic       swap_ff;
	logic       ss_ena_ff;
	logic       status_seen_ff;

	logic       en_w;
	logic       master_w;
	logic       cpol_w;
	logic       cpha_w;
	logic       lsb_w;
	logic       ss_in_w;
	logic       ss_eff_w;
	logic       sel_pin_in_w;
	logic       mode_fault_w;
	logic       busy_w;

	assign en_w     = control_ff[`CR_ENABLE]; // [R15]
	assign master_w = control_ff[`CR_MASTER];
	assign cpol_w   = control_ff[`CR_CPOL];
	assign cpha_w   = control_ff[`CR_CPHA];
	assign lsb_w    = control_ff[`CR_LSB_FIRST];

	// select as input when pin function on: slave always, master when not driven
	assign sel_pin_in_w = ss_ena_ff && (!master_w || !pin_ctrl_ff[`PC_SS_OUT_EN]);
	assign ss_in_w = ss_s_ff[1];
	// internal level when pin function is off [R12]
	assign ss_eff_w = ss_ena_ff ? (master_w ? 1'b1 : ss_in_w) : !master_w ? 1'b0 : 1'b1;
	assign mode_fault_w = en_w && master_w && sel_pin_in_w && !ss_in_w; // [R11] [R10]

	// ***************************************
	// bus decode
	// ***************************************
	logic       req_w;
	logic       wr_w;
	logic [7:0] idx_w;
	logic       hit_ctrl_w;
	logic       hit_data_w;
	logic       hit_stat_w;
	logic       hit_mask_w;
	logic       hit_pin_w;
	logic [7:0] rd_w;

	assign req_w = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wr_w  = req_w && wb_we_i && wb_sel_i[0];
	assign idx_w = wb_adr_i[9:2];
	assign hit_ctrl_w = idx_w == `IDX_CONTROL;
	assign hit_data_w = idx_w == `IDX_DATA;
	assign hit_stat_w = idx_w == `IDX_STATUS;
	assign hit_mask_w = idx_w == `IDX_IRQ_MASK;
	assign hit_pin_w  = idx_w == `IDX_PIN_CTRL;

	always_comb
	begin
		rd_w = `RESET_BYTE;
		if (hit_ctrl_w)
			rd_w = control_ff;
		else if (hit_data_w)
			rd_w = rx_ff;
		else if (hit_stat_w)
			rd_w = {done_ff, write_collision_flag_ff, ss_high_ff, 1'b0, swap_ff, ss_ena_ff, 2'b00};
		else if (hit_mask_w)
			rd_w = mask_ff;
		else if (hit_pin_w)
			rd_w = {6'h00, pin_ctrl_ff};
	end

	// unmapped reads answer zero; every access acks next cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req_w;
			wb_dat_o <= req_w ? {24'h00_0000, rd_w} : 32'h0000_0000;
		end
	end

	// ***************************************
	// shift engine
	// ***************************************
	spi_port_pkg::xfer_state_e state_ff;
	spi_port_pkg::byte_t sh_ff;
	logic [3:0] cnt_ff;
	logic       phase_ff;
	logic       tick_w;
	logic       sclk_lvl_ff;
	logic       data_wr_w;
	logic       start_w;
	logic       rx_bit_w;
	logic       lead_w;
	logic       trail_w;
	logic       sample_w;
	logic       setup_w;
	logic       halt_w;
	logic       out_bit_w;

	assign busy_w    = state_ff != spi_port_pkg::ST_IDLE;
	assign data_wr_w = wr_w && hit_data_w;
	assign start_w   = data_wr_w && !busy_w && en_w && (master_w || !ss_eff_w); // [R03]
	// slave deselect resets state, shift register, count and phase [R09]
	assign halt_w    = !en_w || mode_fault_w || (!master_w && ss_eff_w);

	spi_clk_div u_div
	(
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (master_w && state_ff == spi_port_pkg::ST_SHIFT),
		.rate_i ({control_ff[`CR_DSCR], control_ff[1:0]}),
		.tick_o (tick_w)
	);

	// edges of the idle-relative clock: leading leaves idle level [R16]
	always_comb
	begin
		lead_w  = 1'b0;
		trail_w = 1'b0;
		if (master_w)
		begin
			lead_w  = tick_w && !phase_ff;
			trail_w = tick_w && phase_ff;
		end
		else
		begin
			lead_w  = (sclk_s_ff[1] ^ cpol_w) && !(sclk_q_ff ^ cpol_w);
			trail_w = !(sclk_s_ff[1] ^ cpol_w) && (sclk_q_ff ^ cpol_w);
		end
	end
	assign sample_w = cpha_w ? trail_w : lead_w; // [R16]
	assign setup_w  = cpha_w ? lead_w : trail_w;
	assign rx_bit_w = (master_w ^ swap_ff) ? miso_s_ff[1] : mosi_s_ff[1];
	assign out_bit_w = lsb_w ? sh_ff[0] : sh_ff[7]; // [R01]

	always_ff @(posedge clk_i)
	begin
		if (rst_i || halt_w)
		begin
			state_ff <= spi_port_pkg::ST_IDLE;
			sh_ff    <= `RESET_BYTE;
			cnt_ff   <= 4'h0;
			phase_ff <= 1'b0;
		end
		else
		begin
			unique case (state_ff)
				spi_port_pkg::ST_IDLE:
					if (start_w)
					begin
						state_ff <= spi_port_pkg::ST_SHIFT;
						sh_ff    <= wb_dat_i[7:0];
						cnt_ff   <= 4'h0;
						phase_ff <= 1'b0;
					end
				spi_port_pkg::ST_SHIFT:
				begin
					if (lead_w || trail_w)
						phase_ff <= !phase_ff;
					if (sample_w)
						sh_ff <= lsb_w ? {rx_bit_w, sh_ff[7:1]} : {sh_ff[6:0], rx_bit_w}; // [R04] [R05]
					if (sample_w)
						cnt_ff <= cnt_ff + 4'h1;
					if (setup_w && cnt_ff == `BITS_PER_BYTE)
						state_ff <= spi_port_pkg::ST_DONE;
					else if (sample_w && cpha_w && cnt_ff == `BITS_PER_BYTE - 4'h1)
						state_ff <= spi_port_pkg::ST_DONE;
				end
				spi_port_pkg::ST_DONE:
					state_ff <= spi_port_pkg::ST_IDLE;
			endcase
		end
	end

	// hold the outgoing bit so sampled bit never disturbs it mid-cell
	logic out_ff;
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_ff == spi_port_pkg::ST_IDLE)
			out_ff <= lsb_w ? tx_ff[0] : tx_ff[7];
		else if (state_ff == spi_port_pkg::ST_SHIFT && (setup_w || (cnt_ff == 4'h0 && !phase_ff)))
			out_ff <= out_bit_w;
	end

	// master serial clock toggles on each divider tick [R04] [R17]
	always_ff @(posedge clk_i)
	begin
		if (rst_i || state_ff != spi_port_pkg::ST_SHIFT)
			sclk_lvl_ff <= 1'b0;
		else if (tick_w && cnt_ff != `BITS_PER_BYTE)
			sclk_lvl_ff <= !sclk_lvl_ff;
		else if (tick_w)
			sclk_lvl_ff <= 1'b0;
	end

	// ***************************************
	// data buffer, control, status
	// ***************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			tx_ff <= `RESET_BYTE;
		else if (start_w)
			tx_ff <= wb_dat_i[7:0]; // [R18]
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rx_ff <= `RESET_BYTE;
		else if (state_ff == spi_port_pkg::ST_DONE)
			rx_ff <= sh_ff;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			control_ff <= `RESET_BYTE;
		else if (wr_w && hit_ctrl_w)
			control_ff <= wb_dat_i[7:0];
		else if (mode_fault_w)
			control_ff[`CR_MASTER] <= 1'b0; // [R11]
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mask_ff     <= `RESET_BYTE;
			pin_ctrl_ff <= `PIN_CTRL_RESET;
			swap_ff     <= 1'b0;
			ss_ena_ff   <= 1'b0;
		end
		else
		begin
			if (wr_w && hit_mask_w)
				mask_ff <= wb_dat_i[7:0];
			if (wr_w && hit_pin_w)
				pin_ctrl_ff <= wb_dat_i[1:0]; // [R14]
			if (wr_w && hit_stat_w)
			begin
				swap_ff   <= wb_dat_i[`SR_SWAP];
				ss_ena_ff <= wb_dat_i[`SR_SS_ENA];
			end
		end
	end

	// done flag: set beats any clear [R06] [R07] [R08]
	logic done_set_w;
	logic done_clr_w;
	logic irq_en_w;
	assign irq_en_w   = mask_ff[`SR_DONE];
	assign done_set_w = state_ff == spi_port_pkg::ST_DONE || mode_fault_w;
	assign done_clr_w = irq_en_w ? irq_ack_i
		: (status_seen_ff && req_w && hit_data_w);

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			status_seen_ff <= 1'b0;
		else if (req_w && !wb_we_i && hit_stat_w && done_ff)
			status_seen_ff <= 1'b1;
		else if (req_w && hit_data_w)
			status_seen_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			done_ff <= 1'b0;
		else if (done_set_w)
			done_ff <= 1'b1; // [R06] [R11]
		else if (done_clr_w)
			done_ff <= 1'b0; // [R07] [R08]
	end

	// collision clears on the same status-then-data sequence
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			write_collision_flag_ff <= 1'b0;
		else if (data_wr_w && busy_w)
			write_collision_flag_ff <= 1'b1; // [R18]
		else if (status_seen_ff && req_w && hit_data_w)
			write_collision_flag_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ss_high_ff <= 1'b0;
		else if (ss_ena_ff && sel_pin_in_w && ss_in_w)
			ss_high_ff <= 1'b1; // [R13]
		else if (wr_w && hit_stat_w && !wb_dat_i[`SR_SS_HIGH])
			ss_high_ff <= 1'b0; // [R13]
	end

	// ***************************************
	// pins and interrupt
	// ***************************************
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			irq_o     <= 1'b0;
			sclk_o    <= 1'b0;
			sclk_oe_o <= 1'b0;
			mosi_o    <= 1'b0;
			mosi_oe_o <= 1'b0;
			miso_o    <= 1'b0;
			miso_oe_o <= 1'b0;
			ss_n_o    <= 1'b1;
			ss_n_oe_o <= 1'b0;
		end
		else
		begin
			irq_o     <= |({done_ff, write_collision_flag_ff, ss_high_ff, 5'h00} & mask_ff);
			sclk_o    <= sclk_lvl_ff ^ cpol_w; // [R16]
			sclk_oe_o <= en_w && master_w; // [R04]
			// outgoing line is mosi for master, miso for slave, unless swapped
			mosi_o    <= out_ff;
			mosi_oe_o <= en_w && (master_w ^ swap_ff) && (master_w || !ss_eff_w);
			miso_o    <= out_ff;
			miso_oe_o <= en_w && !(master_w ^ swap_ff) && (master_w || !ss_eff_w); // [R05]
			ss_n_o    <= pin_ctrl_ff[`PC_SS_OUT_LVL]; // [R02] [R14]
			ss_n_oe_o <= master_w && pin_ctrl_ff[`PC_SS_OUT_EN];
		end
	end
endmodule

/* inc/spi_port_params.svh */
// What this block does
// R01 - four-wire full duplex; master or slave; polarity, phase, bit order selectable
// R02 - master selects slave with low select; slave treats low select as chosen
// R03 - writing a byte to the data buffer starts a transfer
// R04 - master drives serial clock, shifts eight bits out and in together
// R05 - slave takes external clock, shifts eight bits out and in on it
// R06 - completion sets done flag in status bit 7; interrupt if enabled
// R07 - with interrupt enabled, acknowledge clears the done flag
// R08 - with interrupt disabled, status read then data access clears done flag
// R09 - slave select high halts and resets serial logic, drops received data
// R10 - master with select as input needs select held high externally
// R11 - master seeing select low becomes slave, sets done flag, interrupts
// R12 - select function disabled: internal select high for master, low for slave
// R13 - select input high sets select-high flag; software clears by writing 0
// R14 - software fixes select direction first; output level set by software
// R15 - control enable bit: 0 disables, 1 enables serial operation
// R16 - phase 0 samples leading edge; phase 1 samples trailing; polarity 1 inverts
// R17 - master serial clock from divider chosen by control rate bits
// R18 - data write during transfer sets write collision, shifted byte untouched
`ifndef SPI_PORT_PARAMS_SVH
`define SPI_PORT_PARAMS_SVH

// ***************************************
// register map, byte addresses = 4 * index
// ***************************************
`define IDX_CONTROL      8'hB5
`define IDX_DATA         8'hB6
`define IDX_STATUS       8'hB7
`define IDX_IRQ_MASK     8'hB8
`define IDX_PIN_CTRL     8'hB9
`define ADDR_W           10

// ***************************************
// field positions
// ***************************************
`define CR_ENABLE        7
`define CR_LSB_FIRST     6
`define CR_MASTER        5
`define CR_CPOL          4
`define CR_CPHA          3
`define CR_DSCR          2
`define SR_DONE          7
`define SR_WRITE_COLLISION_FLAG          6
`define SR_SS_HIGH       5
`define SR_SWAP          3
`define SR_SS_ENA        2
`define PC_SS_OUT_EN     0
`define PC_SS_OUT_LVL    1
`define PIN_CTRL_RESET   2'b10
`define RESET_BYTE       8'h00
`define BITS_PER_BYTE    4'h8

`endif

/* inc/spi_port_pkg.sv */
package spi_port_pkg;
	typedef enum logic [2:0]
	{
		ST_IDLE  = 3'b001,
		ST_SHIFT = 3'b010,
		ST_DONE  = 3'b100
	} xfer_state_e;
	typedef logic [7:0] byte_t;
endpackage

/* src/spi_clk_div.sv */
`timescale 1ns/1ps
// ***************************************
// master rate divider: one tick per half serial period
// ***************************************
module spi_clk_div
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// control
	input  wire logic       run_i,
	input  wire logic [2:0] rate_i,
	// tick
	output logic            tick_o
);
	logic [6:0] cnt_ff;
	logic [6:0] half_w;

	// half period in clocks per rate code
	function automatic logic [6:0] half_of(input logic [2:0] r);
		unique case (r)
			3'h0: half_of = 7'h02;
			3'h1: half_of = 7'h08;
			3'h2: half_of = 7'h20;
			3'h3: half_of = 7'h40;
			3'h4: half_of = 7'h01;
			3'h5: half_of = 7'h04;
			3'h6: half_of = 7'h10;
			default: half_of = 7'h40;
		endcase
	endfunction

	assign half_w = half_of(rate_i);

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !run_i || tick_o)
			cnt_ff <= 7'h01;
		else
			cnt_ff <= cnt_ff + 7'h01;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || !run_i)
			tick_o <= 1'b0;
		else
			// fastest rate ticks every clock, others skip one after each tick
			tick_o <= (half_w == 7'h01) || (!tick_o && (cnt_ff >= half_w - 7'h01)); // [R17]
	end
endmodule

/* verification/spi_port_asserts.sv */
`timescale 1ns/1ps
module spi_port_asserts
(
	// clock and reset
	input	wire logic		clk_i,
	input	wire logic		rst_i,
	// bus
	input	wire logic		wb_cyc_i,
	input	wire logic		wb_stb_i,
	input	wire logic		wb_we_i,
	input	wire logic [31:0]	wb_dat_o,
	input	wire logic		wb_ack_o,
	// interrupt and pins
	input	wire logic		irq_o,
	input	wire logic		irq_ack_i,
	input	wire logic		ss_n_o,
	input	wire logic		sclk_oe_o,
	input	wire logic		mosi_oe_o,
	input	wire logic		miso_oe_o
);
	logic [3:0]	quiet_ff;
	logic [3:0]	nxt_quiet;
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ***********************
	// cycles since last bus or acknowledge activity
	// ***********************
	assign nxt_quiet = (wb_cyc_i || irq_ack_i) ? 4'h0 : quiet_ff + {3'h0, quiet_ff != 4'hF};
	// zero on reset: a flag cleared by reset may still look like a fall
	always_ff @(posedge clk_i)
		quiet_ff <= rst_i ? 4'h0 : nxt_quiet;
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_ans;
		wb_ack_o ##1 !wb_ack_o;
	endsequence
	chk_bus_answer: assert property (s_req |=> s_ans)
		else $error("no single ack after request");
	chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	chk_read_upper: assert property (wb_ack_o && !wb_we_i |-> wb_dat_o[31:8] == 24'h00_0000)
		else $error("upper read bits not zero");
	chk_reset_state: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && ss_n_o)
		else $error("outputs not at reset level");
	chk_one_out: assert property (!(mosi_oe_o && miso_oe_o))
		else $error("both data lines driven");
	chk_master_out: assert property (sclk_oe_o |-> mosi_oe_o || miso_oe_o)
		else $error("master drives clock without data");
	chk_irq_drop: assert property ($fell(irq_o) |-> quiet_ff < 4'h4)
		else $error("interrupt fell without cause");
	chk_sel_soft: assert property ($changed(ss_n_o) |-> $past(wb_cyc_i && wb_we_i))
		else $error("select level moved without write");
endmodule

bind spi_port spi_port_asserts u_chk
(
	.clk_i(clk_i),
	.rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i),
	.wb_we_i(wb_we_i),
	.wb_dat_o(wb_dat_o),
	.wb_ack_o(wb_ack_o),
	.irq_o(irq_o),
	.irq_ack_i(irq_ack_i),
	.ss_n_o(ss_n_o),
	.sclk_oe_o(sclk_oe_o),
	.mosi_oe_o(mosi_oe_o),
	.miso_oe_o(miso_oe_o)
);

/* verification/spi_slave_model.sv */
`timescale 1ns/1ps
module spi_slave_model
(
	// serial side
	input	wire logic		sclk_i,
	input	wire logic		sel_n_i,
	input	wire logic		mosi_i,
	output	logic			miso_o,
	// setup
	input	wire logic		cpol_i,
	input	wire logic		cpha_i,
	input	wire logic [7:0]	tx_i,
	output	logic [7:0]		rx_o
);
	logic [7:0]	sh;
	logic		ob;
	// ***********************
	// load on select, shift on link edges
	// ***********************
	always @(negedge sel_n_i)
	begin
		ob = cpha_i ? ~tx_i[7] : tx_i[7];
		sh = cpha_i ? tx_i : {tx_i[6:0], 1'b0};
	end
	always @(sclk_i)
	begin
		if (sel_n_i === 1'b0)
		begin
			if ((sclk_i != cpol_i) != cpha_i)
				rx_o = {rx_o[6:0], mosi_i};
			else
			begin
				ob = sh[7];
				sh = {sh[6:0], 1'b0};
			end
		end
	end
	// released line shows the inverse, never a stale bit
	assign miso_o = sel_n_i ? ~ob : ob;
endmodule

/* verification/spi_port_tb_top.sv */
`timescale 1ns/1ps
module spi_port_tb_top;
	// ***********************
	// bench state
	// ***********************
	logic		clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq_o, irq_ack_i;
	logic		sclk_i, sclk_o, sclk_oe_o, mosi_i, mosi_o, mosi_oe_o, miso_i, miso_o;
	logic		miso_oe_o, ss_n_i, ss_n_o, ss_n_oe_o, lsb;
	logic [1:0]	md;
	logic [9:0]	wb_adr_i;
	logic [31:0]	wb_dat_i, wb_dat_o, seed;
	logic [7:0]	tx, s_tx, s_rx, got;
	logic [15:0]	cur;
	logic [15:0]	expq[$];
	string		nmq[$];
	int		err_total, tests_run;
	localparam logic [9:0] A_CR = 10'h2D4, A_DR = 10'h2D8, A_SR = 10'h2DC, A_MK = 10'h2E0;
	localparam logic [9:0] A_PC = 10'h2E4, A_NONE = 10'h3FC;
	localparam logic [9:0] RST_ADR [5] = '{A_CR, A_DR, A_SR, A_MK, A_NONE};
	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end
	spi_port dut
	(
		.clk_i(clk_i),
		.rst_i(rst_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(4'h1),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.irq_o(irq_o),
		.irq_ack_i(irq_ack_i),
		.sclk_i(sclk_i),
		.sclk_o(sclk_o),
		.sclk_oe_o(sclk_oe_o),
		.mosi_i(mosi_i),
		.mosi_o(mosi_o),
		.mosi_oe_o(mosi_oe_o),
		.miso_i(miso_i),
		.miso_o(miso_o),
		.miso_oe_o(miso_oe_o),
		.ss_n_i(ss_n_i),
		.ss_n_o(ss_n_o),
		.ss_n_oe_o(ss_n_oe_o)
	);
	spi_slave_model partner
	(
		.sclk_i(sclk_o),
		.sel_n_i(ss_n_oe_o ? ss_n_o : 1'b1),
		.mosi_i(mosi_o),
		.miso_o(miso_i),
		.cpol_i(md[1]),
		.cpha_i(md[0]),
		.tx_i(s_tx),
		.rx_o(s_rx)
	);
	// ***********************
	// helpers
	// ***********************
	function logic [7:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	function logic [7:0] rev(input logic [7:0] v);
		rev = {<<{v}};
	endfunction
	task results();
		$display("checks %0d errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task bus(input logic we, input logic [9:0] a, input logic [7:0] d);
		int n;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h00_0000, d};
		n = 0;
		do
			@(posedge clk_i);
		while (wb_ack_o !== 1'b1 && ++n < 40);
		if (n >= 40)
		begin
			err_total++;
			results();
		end
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task rd(input string nm, input logic [9:0] a, input logic [7:0] m, input logic [7:0] e);
		nmq.push_back(nm);
		expq.push_back({m, e});
		bus(1'b0, a, 8'h00);
	endtask
	task wait_irq();
		int n;
		for (n = 0; irq_o !== 1'b1 && n < 900; n++)
			@(posedge clk_i);
		if (n >= 900)
		begin
			err_total++;
			results();
		end
	endtask
	task ack_irq();
		irq_ack_i <= 1'b1;
		@(posedge clk_i);
		irq_ack_i <= 1'b0;
		@(posedge clk_i);
	endtask
	// bench as link master, mode 0, msb first, 125 ns average period on clock edges
	task ext(input logic [7:0] b, input int nb);
		realtime t;
		t = $realtime;
		for (int k = 7; k > 7 - nb; k--)
		begin
			mosi_i <= b[k];
			t = t + 62.5;
			while ($realtime < t)
				@(posedge clk_i);
			got[k] = miso_o;
			sclk_i <= 1'b1;
			t = t + 62.5;
			while ($realtime < t)
				@(posedge clk_i);
			sclk_i <= 1'b0;
		end
		mosi_i <= ~mosi_i;
	endtask
	// read results, oldest note first
	always @(posedge clk_i)
	begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
		begin
			// a read nobody noted is always a mismatch
			if (expq.size() == 0)
				chk("extra read", 8'h01, 8'h00);
			else
			begin
				cur = expq.pop_front();
				chk(nmq.pop_front(), wb_dat_o[7:0] & cur[15:8], cur[7:0]);
			end
		end
	end
	// ***********************
	// main sequence
	// ***********************
	initial
	begin
		{rst_i, wb_cyc_i, wb_stb_i, wb_we_i, irq_ack_i, sclk_i, mosi_i, ss_n_i} = 8'h81;
		{wb_adr_i, wb_dat_i, md, err_total, tests_run} = '0;
		seed = 32'h0000_CB03;
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		bus(1'b1, A_NONE, 8'hFF);
		foreach (RST_ADR[k])
			rd("reset value", RST_ADR[k], 8'hFF, 8'h00);
		// select pin direction fixed before any control write
		bus(1'b1, A_PC, 8'h03);
		// master, every polarity and phase; internal select stays high
		for (int i = 0; i < 4; i++)
		begin
			md <= i[1:0];
			lsb = (i == 3);
			tx = rnd();
			s_tx = rnd();
			bus(1'b1, A_MK, 8'h80);
			bus(1'b1, A_CR, {1'b1, lsb, 1'b1, i[1:0], 3'h1});
			bus(1'b1, A_PC, 8'h01);
			bus(1'b1, A_DR, tx);
			bus(1'b1, A_DR, ~tx);
			wait_irq();
			chk("slave rx", s_rx, lsb ? rev(tx) : tx);
			if (i[0])
			begin
				bus(1'b1, A_MK, 8'h00);
				rd("status", A_SR, 8'hC0, 8'hC0);
			end
			else
				ack_irq();
			rd("rx byte", A_DR, 8'hFF, lsb ? rev(s_tx) : s_tx);
			rd("status", A_SR, i[0] ? 8'hC0 : 8'h80, 8'h00);
			bus(1'b1, A_PC, 8'h03);
		end
		// slave with select pin
		bus(1'b1, A_MK, 8'h80);
		bus(1'b1, A_CR, 8'h80);
		bus(1'b1, A_SR, 8'h04);
		rd("select high", A_SR, 8'h20, 8'h20);
		ss_n_i <= 1'b0;
		// let the synchroniser settle, else the set beats the clear
		repeat (4) @(posedge clk_i);
		bus(1'b1, A_SR, 8'h04);
		rd("select high", A_SR, 8'h20, 8'h00);
		tx = rnd();
		s_tx = rnd();
		bus(1'b1, A_DR, tx);
		ext(s_tx, 8);
		chk("master rx", got, tx);
		wait_irq();
		rd("rx byte", A_DR, 8'hFF, s_tx);
		ack_irq();
		bus(1'b1, A_DR, tx);
		ext(s_tx, 4);
		ss_n_i <= 1'b1;
		repeat (300) @(posedge clk_i);
		rd("aborted", A_SR, 8'h80, 8'h00);
		// master with pin as input, then pulled low
		bus(1'b1, A_PC, 8'h00);
		bus(1'b1, A_CR, 8'hA1);
		ss_n_i <= 1'b0;
		wait_irq();
		rd("mode", A_CR, 8'h20, 8'h00);
		rd("status", A_SR, 8'h80, 8'h80);
		ack_irq();
		bus(1'b1, A_CR, 8'h21);
		bus(1'b1, A_DR, tx);
		repeat (300) @(posedge clk_i);
		rd("disabled", A_SR, 8'h80, 8'h00);
		results();
	end
endmodule
